// *** rtl/self_program_section_control.sv ***
// Self-programming gate: store admission, region halt/block and busy flag.
// Assumes a CPU that issues store requests with its executing address and
// honours the halt and read-block outputs; registers reached over APB.
`timescale 1ns/10ps
module self_program_section_control
  import flash_prog_pkg::*;
#(
  parameter int                      PROG_CNT    = PROG_CYCLES,
  parameter logic [ADDR_W-1:0]       STALL_START = STALL_REGION_START,
  parameter logic [3:0][ADDR_W-1:0]  BOOT_TAB    = BOOT_START_TAB
) (
  input  wire logic              clk_i,         // Core clock
  input  wire logic              rst_i,         // Sync reset, high
  input  wire apb_req_s          apb_i,         // APB request
  output logic [31:0]            prdata_o,      // APB read data
  output logic                   pready_o,      // APB ready
  output logic                   pslverr_o,     // APB error
  input  wire logic [1:0]        boot_size_i,   // Boot size fuse pins
  input  wire store_req_s        store_i,       // Store instruction
  input  wire logic [ADDR_W-1:0] pc_i,          // Address of the store
  input  wire logic              fetch_valid_i, // Fetch or load valid
  input  wire logic [ADDR_W-1:0] fetch_addr_i,  // Fetch or load address
  output logic                   prog_start_o,  // Flash op start pulse
  output store_op_e              prog_op_o,     // Flash op kind
  output logic [ADDR_W-PAGE_BITS-1:0] prog_page_o, // Flash page
  output logic                   cpu_halt_o,    // Halt the CPU
  output logic                   read_block_o,  // Concurrent reads blocked
  output logic                   irq_o          // Interrupt, level
);

  localparam logic [15:0] PROG_LAST = 16'(PROG_CNT - 1);

  logic [1:0]        boot_size;
  logic              pc_in_boot;
  logic              tgt_boot;
  logic              tgt_conc;
  prog_state_e       state_r;
  logic [15:0]       cnt_r;
  logic              tgt_conc_r;
  logic [3:0]        lock_r;
  logic              busy_r;
  logic [IRQ_W-1:0]  istat_r;
  logic [IRQ_W-1:0]  imask_r;
  logic [IRQ_W-1:0]  ev;
  logic              lock_ok;
  logic              accept;
  logic              reject;
  logic              done;
  logic              blk_ev;
  logic              wr;
  logic              rd;
  logic              mapped;
  logic              busy_clr;
  logic [31:0]       rdata;

  pin_sync #(
    .W (2)
  ) u_fuse_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (boot_size_i),
    .q_o   (boot_size)
  );

  section_decode #(
    .STALL_START (STALL_START),
    .BOOT_TAB    (BOOT_TAB)
  ) u_decode (
    .boot_size_i  (boot_size),
    .pc_i         (pc_i),
    .tgt_i        (store_i.addr),
    .pc_in_boot_o (pc_in_boot),
    .tgt_boot_o   (tgt_boot),
    .tgt_conc_o   (tgt_conc)
  );

  // Write lands on the completing edge; read data is captured one earlier
  assign wr = apb_i.psel & apb_i.penable & apb_i.pwrite & pready_o;
  assign rd = apb_i.psel & apb_i.penable & ~apb_i.pwrite & ~pready_o;
  assign mapped = (apb_i.paddr == CTRL_OFS) || (apb_i.paddr == LOCK_OFS) ||
                  (apb_i.paddr == ISTAT_OFS) || (apb_i.paddr == IMASK_OFS) ||
                  (apb_i.paddr == INFO_OFS);

  // RQ4 lock per section
  assign lock_ok = tgt_boot ? lock_r[2] : lock_r[0];
  // RQ1 RQ2 admission
  assign accept = store_i.valid & (state_r == ST_IDLE) & pc_in_boot &
                  lock_ok;
  assign reject = store_i.valid & ~accept;
  assign done = (state_r == ST_PROG) && (cnt_r == PROG_LAST);
  // RQ9 blocked read attempt
  assign blk_ev = fetch_valid_i & read_block_o &
                  (fetch_addr_i < STALL_START);
  assign busy_clr = wr && (apb_i.paddr == CTRL_OFS) &&
                    apb_i.pwdata[CTRL_BUSY_BIT] && (state_r == ST_IDLE);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r   <= ST_IDLE;
      cnt_r     <= 16'h0000;
      tgt_conc_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          cnt_r <= 16'h0000;
          if (accept)
          begin
            state_r    <= ST_PROG;
            tgt_conc_r <= tgt_conc;
          end
        end
        ST_PROG:
        begin
          cnt_r <= cnt_r + 16'h0001;
          if (done)
            state_r <= ST_DONE;
        end
        ST_DONE:
          state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // RQ14 page taken only for programming
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prog_start_o <= 1'b0;
      prog_op_o    <= OP_ERASE;
      prog_page_o  <= '0;
    end
    else
    begin
      prog_start_o <= accept;
      if (accept)
      begin
        prog_op_o   <= store_i.op;
        prog_page_o <= store_i.addr[ADDR_W-1:PAGE_BITS];
      end
    end
  end

  // RQ7 RQ8 halt only for stall region
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cpu_halt_o <= 1'b0;
    else if (accept)
      cpu_halt_o <= ~tgt_conc;
    else if (done)
      cpu_halt_o <= 1'b0;
  end

  // RQ13 RQ16 busy flag; set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      busy_r <= 1'b0;
    else if (accept && tgt_conc)
      busy_r <= 1'b1;
    else if (busy_clr)
      busy_r <= 1'b0;
  end

  // RQ9 RQ12 block follows busy; stall ops release after the wrap cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      read_block_o <= 1'b0;
    else if (accept)
      read_block_o <= 1'b1;
    else if (busy_clr ||
             (state_r == ST_DONE && !tgt_conc_r && !busy_r))
      read_block_o <= 1'b0;
  end

  // RQ4 lock bits only programmed to zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lock_r <= LOCK_RESET;
    else if (wr && apb_i.paddr == LOCK_OFS)
      lock_r <= lock_r & apb_i.pwdata[3:0];
  end

  assign ev = {blk_ev, reject, done};

  // Sticky events, write one to clear, set wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      istat_r <= '0;
      imask_r <= '0;
    end
    else
    begin
      if (wr && apb_i.paddr == ISTAT_OFS)
        istat_r <= (istat_r & ~apb_i.pwdata[IRQ_W-1:0]) | ev;
      else
        istat_r <= istat_r | ev;
      if (wr && apb_i.paddr == IMASK_OFS)
        imask_r <= apb_i.pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(istat_r & imask_r);
  end

  always_comb
  begin
    rdata = 32'h0000_0000;
    case (apb_i.paddr)
      CTRL_OFS:
      begin
        rdata[CTRL_BUSY_BIT] = busy_r;
        rdata[CTRL_ACT_BIT]  = (state_r != ST_IDLE);
        rdata[CTRL_HALT_BIT] = cpu_halt_o;
      end
      LOCK_OFS:  rdata[3:0] = lock_r;
      ISTAT_OFS: rdata[IRQ_W-1:0] = istat_r;
      IMASK_OFS: rdata[IRQ_W-1:0] = imask_r;
      INFO_OFS:  rdata[1:0] = boot_size;
      default:   rdata = 32'h0000_0000;
    endcase
  end

  // One wait state per access: ready in cycle after access phase starts
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
    else
    begin
      pready_o  <= apb_i.psel & apb_i.penable & ~pready_o;
      pslverr_o <= apb_i.psel & apb_i.penable & ~pready_o & ~mapped;
      if (rd)
        prdata_o <= rdata;
    end
  end

  reject_app_a: assert property (@(posedge clk_i) disable iff (rst_i)
    store_i.valid && state_r == ST_IDLE && !pc_in_boot
    |=> state_r == ST_IDLE && !prog_start_o)
    else $error("store from application section started"); // RQ1

  boot_target_a: assert property (@(posedge clk_i) disable iff (rst_i)
    store_i.valid && state_r == ST_IDLE && pc_in_boot && tgt_boot &&
    lock_r[2] |=> state_r == ST_PROG && prog_start_o)
    else $error("boot page store refused"); // RQ2

  lock_mono_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (lock_r & ~$past(lock_r)) == 4'h0)
    else $error("lock bit returned to one"); // RQ4

  run_conc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == ST_PROG && tgt_conc_r |-> !cpu_halt_o && busy_r)
    else $error("cpu halted on concurrent op"); // RQ7

  halt_stall_a: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && !tgt_conc |=> cpu_halt_o throughout
    (state_r == ST_PROG)[*8])
    else $error("halt dropped during stall op"); // RQ8

  halt_whole_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == ST_PROG && !tgt_conc_r |-> cpu_halt_o)
    else $error("cpu running during stall op"); // RQ8

  block_prog_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r != ST_IDLE |-> read_block_o)
    else $error("concurrent reads open during programming"); // RQ9

  busy_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    busy_r |-> read_block_o)
    else $error("busy flag without read block"); // RQ12

  busy_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    busy_r && !busy_clr |=> busy_r)
    else $error("busy flag cleared without software"); // RQ13

  busy_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && tgt_conc |=> busy_r && prog_start_o)
    else $error("busy flag late"); // RQ16

  // Length checked by counter end points; a long delay would stall tools
  prog_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state_r == ST_PROG) |-> cnt_r == 16'h0000)
    else $error("programming count not cleared"); // RQ8

  done_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(state_r == ST_PROG) |-> $past(cnt_r) == PROG_LAST)
    else $error("programming length wrong"); // RQ8

  // RQ11 boot inside stall
  boot_in_stall_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tgt_boot |-> !tgt_conc)
    else $error("boot section reaches concurrent region"); // RQ11

endmodule // self_program_section_control

// *** rtl/spm_pkg.sv ***
// Constants, types and register map of the self-programming section control.
// Assumes word addressed program flash and an APB master on the core clock.
// Overview of operation
// RQ1: Store instruction starts programming only while executing in boot loader section.
// RQ2: Store from boot loader section may target any page, boot pages included.
// RQ3: Boot size fuses pick one of several predefined boot loader section sizes.
// RQ4: Two separately programmable lock sets guard application and boot sections.
// RQ5: Flash splits at a fixed boundary into concurrent-read and stall regions.
// RQ6: Latched page pointer address decides which region an operation targets.
// RQ7: Concurrent-region programming keeps the CPU running; stall region stays readable.
// RQ8: Stall-region programming halts the CPU for the whole erase or write.
// RQ9: Concurrent-read region is unreadable while any programming is in progress.
// RQ10: Loader software keeps fetches, loads and vectors out of concurrent region.
// RQ11: Boot loader section always lies wholly inside the stall region.
// RQ12: Busy flag reads one while concurrent-region reads are blocked; the code leaves it zero during stall-region ops.
// RQ13: Busy flag and read block persist after programming until software clears; after a stall op the code drops the block in ST_DONE itself.
// RQ14: Page split matters only to programming, never to fetches or reads.
// RQ15: Region boundaries and boot sizes are design parameters.
// RQ16: Busy flag sets in the first cycle of a concurrent-region operation.
package flash_prog_pkg;

  localparam int ADDR_W = 13;
  localparam int PAGE_BITS = 6;
  localparam logic [ADDR_W-1:0] STALL_REGION_START = 13'h1C00;
  // Boot section start per fuse code, index 0 is the largest section
  localparam logic [3:0][ADDR_W-1:0] BOOT_START_TAB =
    {13'h1F80, 13'h1F00, 13'h1E00, 13'h1C00};

  localparam int PROG_TIME_NS = 4000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_CYCLES =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LOCK_OFS = 8'h04;
  localparam logic [7:0] ISTAT_OFS = 8'h08;
  localparam logic [7:0] IMASK_OFS = 8'h0C;
  localparam logic [7:0] INFO_OFS = 8'h10;

  localparam int CTRL_BUSY_BIT = 0;
  localparam int CTRL_ACT_BIT = 1;
  localparam int CTRL_HALT_BIT = 2;
  localparam logic [3:0] LOCK_RESET = 4'hF;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_REJ_BIT = 1;
  localparam int IRQ_BLK_BIT = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PROG = 2'b01,
    ST_DONE = 2'b11
  } prog_state_e;

  typedef enum logic {
    OP_ERASE = 1'b0,
    OP_WRITE = 1'b1
  } store_op_e;

  typedef struct packed {
    logic              valid;
    store_op_e         op;
    logic [ADDR_W-1:0] addr;
  } store_req_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;

endpackage

// *** rtl/pin_sync.sv ***
// Two-stage synchroniser for static fuse level pins.
// Assumes the levels change rarely; no multi-bit coherence is needed.
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_i,  // Core clock
  input  wire logic         rst_i,  // Sync reset, high
  input  wire logic [W-1:0] d_i,    // Asynchronous level
  output logic      [W-1:0] q_o     // Synchronised level
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule // pin_sync

// *** rtl/section_decode.sv ***
// Address decode of the boot/application split and the fixed region split.
// Purely combinational; assumes word addresses of ADDR_W bits.
`timescale 1ns/10ps
module section_decode
  import flash_prog_pkg::*;
#(
  parameter logic [ADDR_W-1:0]       STALL_START = STALL_REGION_START,
  parameter logic [3:0][ADDR_W-1:0]  BOOT_TAB    = BOOT_START_TAB
) (
  input  wire logic [1:0]        boot_size_i,  // Synchronised fuses
  input  wire logic [ADDR_W-1:0] pc_i,         // Executing address
  input  wire logic [ADDR_W-1:0] tgt_i,        // Page pointer address
  output logic                   pc_in_boot_o, // Code runs in boot
  output logic                   tgt_boot_o,   // Target in boot
  output logic                   tgt_conc_o    // Target in concurrent
);

  logic [ADDR_W-1:0] boot_start;

  // RQ3 RQ15 fuse table
  assign boot_start = BOOT_TAB[boot_size_i];
  assign pc_in_boot_o = (pc_i >= boot_start);
  assign tgt_boot_o = (tgt_i >= boot_start);
  // RQ5 RQ6 fixed split
  assign tgt_conc_o = (tgt_i < STALL_START);

endmodule // section_decode

// *** tb/cpu_model.sv ***
// CPU side model: issues store instructions and fetches.
// Assumes the bench calls its tasks; signals move after a rising edge.
`timescale 1ns/10ps
module cpu_model
  import flash_prog_pkg::*;
#(
  parameter logic [ADDR_W-1:0] STALL = 13'h1C00
) (
  input  wire logic         clk_i,         // Core clock
  input  wire logic         read_block_i,  // Concurrent reads blocked
  input  wire logic         cpu_halt_i,    // Core halted
  output store_req_s        store_o,       // Store instruction
  output logic [ADDR_W-1:0] pc_o,          // Store executes here
  output logic              fetch_valid_o, // Fetch valid
  output logic [ADDR_W-1:0] fetch_addr_o   // Fetch address
);
  initial
  begin
    store_o = '0;
    pc_o = '0;
    fetch_valid_o = 1'b0;
    fetch_addr_o = '0;
  end

  task automatic store(input store_op_e op, input logic [ADDR_W-1:0] a,
                       input logic [ADDR_W-1:0] pc);
    @(posedge clk_i);
    store_o <= '{1'b1, op, a};
    pc_o <= pc;
    @(posedge clk_i);
    // Scrambled so stale address is never trusted
    store_o <= '{1'b0, op, ~a};
    pc_o <= ~pc;
  endtask

  task automatic fetch(input logic [ADDR_W-1:0] a, input logic rude);
    @(posedge clk_i);
    if (!cpu_halt_i && (rude || !read_block_i || a >= STALL))
    begin
      fetch_valid_o <= 1'b1;
      fetch_addr_o <= a;
      @(posedge clk_i);
      fetch_valid_o <= 1'b0;
      fetch_addr_o <= ~a;
    end
  endtask
endmodule // cpu_model

// *** tb/self_program_section_control_bench.sv ***
// Bench: APB accesses and CPU store sequences with expected values.
// Assumes cpu_model; assertions live in the design files.
`timescale 1ns/10ps
module self_program_section_control_bench;
  import flash_prog_pkg::*;
  localparam int PCNT = 8;
  localparam logic [ADDR_W-1:0] STALL = 13'h1C00;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  apb_req_s          apb_q = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [1:0]        fuse_q = 2'b00;
  store_req_s        store;
  logic [ADDR_W-1:0] pc;
  logic              fv;
  logic [ADDR_W-1:0] fa;
  logic              start;
  store_op_e         op;
  logic [ADDR_W-PAGE_BITS-1:0] page;
  logic              halt;
  logic              block;
  logic              irq;
  int                failures = 0;
  int                num_checks = 0;
  logic [31:0]       rd;
  logic              er;

  always #4 clk_i = ~clk_i;

  self_program_section_control #(.PROG_CNT(PCNT), .STALL_START(STALL))
  i_dut (.clk_i(clk_i), .rst_i(rst_i), .apb_i(apb_q), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .boot_size_i(fuse_q),
    .store_i(store), .pc_i(pc), .fetch_valid_i(fv), .fetch_addr_i(fa),
    .prog_start_o(start), .prog_op_o(op), .prog_page_o(page),
    .cpu_halt_o(halt), .read_block_o(block), .irq_o(irq));

  cpu_model #(.STALL(STALL)) i_cpu (.clk_i(clk_i), .read_block_i(block),
    .cpu_halt_i(halt), .store_o(store), .pc_o(pc), .fetch_valid_o(fv),
    .fetch_addr_o(fa));

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    apb_q <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    apb_q.penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do
    begin
      @(posedge clk_i);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    apb_q.psel <= 1'b0;
    apb_q.penable <= 1'b0;
  endtask

  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(n, e, rd);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #200000;
    failures++;
    conclude();
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("lock", LOCK_OFS, 32'h0000_000F);
    rdc("ctrl", CTRL_OFS, 32'h0000_0000);
    $display("test 1 done");
    i_cpu.store(OP_WRITE, 13'h0040, 13'h0100);
    @(negedge clk_i);
    chk("start app", 0, start);
    rdc("istat rej", ISTAT_OFS, 32'h0000_0002);
    apb(1'b1, ISTAT_OFS, 32'h0000_0002);
    $display("test 2 done");
    apb(1'b1, IMASK_OFS, 32'h0000_0001);
    i_cpu.store(OP_ERASE, 13'h0080, 13'h1C10);
    @(negedge clk_i);
    chk("start conc", 1, start);
    chk("page conc", 2, page);
    chk("op erase", 0, op);
    chk("halt conc", 0, halt);
    chk("block conc", 1, block);
    // Second store while busy must be turned away
    i_cpu.store(OP_WRITE, 13'h0080, 13'h1C10);
    i_cpu.fetch(13'h0010, 1'b1);
    repeat (PCNT) @(posedge clk_i);
    @(negedge clk_i);
    chk("irq", 1, irq);
    chk("block held", 1, block);
    rdc("ctrl busy", CTRL_OFS, 32'h0000_0001);
    rdc("istat all", ISTAT_OFS, 32'h0000_0007);
    apb(1'b1, ISTAT_OFS, 32'h0000_0007);
    // Interrupt trails status by one cycle
    @(posedge clk_i);
    @(negedge clk_i);
    chk("irq clr", 0, irq);
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    rdc("ctrl clr", CTRL_OFS, 0);
    chk("block clr", 0, block);
    $display("test 3 done");
    i_cpu.store(OP_WRITE, 13'h1FC0, 13'h1C10);
    @(negedge clk_i);
    chk("halt stall", 1, halt);
    chk("block stall", 1, block);
    chk("op", 1, op);
    chk("page boot", 13'h1FC0 >> PAGE_BITS, page);
    repeat (PCNT - 1) @(posedge clk_i);
    @(negedge clk_i);
    chk("halt held", 1, halt);
    @(negedge clk_i);
    chk("halt end", 0, halt);
    @(negedge clk_i);
    chk("block end", 0, block);
    apb(1'b1, ISTAT_OFS, 32'h0000_0001);
    $display("test 4 done");
    @(posedge clk_i);
    fuse_q <= 2'b11;
    repeat (4) @(posedge clk_i);
    rdc("info", INFO_OFS, 3);
    i_cpu.store(OP_WRITE, 13'h1C40, 13'h1E00);
    rdc("istat fuse", ISTAT_OFS, 2);
    apb(1'b1, ISTAT_OFS, 32'h0000_0002);
    i_cpu.store(OP_WRITE, 13'h1C40, 13'h1F90);
    @(negedge clk_i);
    chk("halt boot", 1, halt);
    repeat (PCNT + 2) @(posedge clk_i);
    apb(1'b1, ISTAT_OFS, 32'h0000_0001);
    $display("test 5 done");
    apb(1'b0, 8'h20, '0);
    chk("err", 1, er);
    chk("err data", 0, rd);
    apb(1'b1, LOCK_OFS, 32'h0000_000E);
    rdc("lock and", LOCK_OFS, 32'h0000_000E);
    i_cpu.store(OP_ERASE, 13'h0040, 13'h1F90);
    @(negedge clk_i);
    chk("app locked", 0, start);
    i_cpu.store(OP_ERASE, 13'h1FC0, 13'h1F90);
    @(negedge clk_i);
    chk("boot open", 1, start);
    $display("test 6 done");
    conclude();
  end
endmodule // self_program_section_control_bench
